// >>> dsl_fifo.sv
// module: parameterised sample fifo with valid/ready both sides
module dsl_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // fill side
  dsl_fifo_if.snk in_s,
  // drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // honest flags from the occupancy count
  assign in_s.ready = (cnt_r != AW'(0) + (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push = in_s.valid && in_s.ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rp_r];
  assign level = cnt_r;

  // storage array, no reset needed on data
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wp_r] <= in_s.data;
    end
  end

  // pointers and count
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + AW'(1);
      end
      if (pop) begin
        rp_r <= rp_r + AW'(1);
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + (AW+1)'(1);
      end else if (pop && !push) begin
        cnt_r <= cnt_r - (AW+1)'(1);
      end
    end
  end

  // never reports beyond depth
  a_fifo_bound: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cnt_r <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule : dsl_fifo

// >>> dsl_fifo_if.sv
// interface: valid/ready word stream between latch and fifo
interface dsl_fifo_if #(
  parameter int W = 14
);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : dsl_fifo_if

// >>> dsl_host_model.sv
// host model: drives each sample word as differential line pairs
module dsl_host_model
  import dsl_pkg::*;
(
  // word and line levels chosen by the bench
  input wire logic [DSL_WORD_W-1:0] word,
  input wire logic signed [DSL_DIFF_W-1:0] half_mv,
  input wire logic signed [DSL_DIFF_W-1:0] cm_mv,
  // differential lines toward the latch
  output logic signed [DSL_DIFF_W-1:0] true_mv [DSL_WORD_W],
  output logic signed [DSL_DIFF_W-1:0] comp_mv [DSL_WORD_W]
);
  // ==========================================================
  // line drive
  // bit i on pair i
  // one word a clock; true line above complement for a one
  always_comb begin
    for (int i = 0; i < DSL_WORD_W; i++) begin
      true_mv[i] = word[i] ? cm_mv + half_mv : cm_mv - half_mv;
      comp_mv[i] = word[i] ? cm_mv - half_mv : cm_mv + half_mv;
    end
  end
endmodule : dsl_host_model

// >>> dsl_pkg.sv
// package: constants and types for the sample input latch
package dsl_pkg;
  // sample word width, msb is bit 13
  localparam int DSL_WORD_W = 14;
  localparam int DSL_MSB = 13;
  localparam int DSL_LSB = 0;
  // fixed latency in converter clocks with the delay loop bypassed
  localparam int DSL_LAT_CLK = 3;
  // fifo depth on the sample path
  localparam int DSL_FIFO_DEPTH = 16;
  // differential threshold and max swing in mV (signed input units)
  localparam int DSL_DIFF_W = 12;
  localparam logic signed [11:0] DSL_TH_MV = 12'sd100;
  localparam logic signed [11:0] DSL_SWING_MV = 12'sd600;
  // reset value and all-ones code
  localparam logic [13:0] DSL_WORD_RST = 14'h0000;
  localparam logic [13:0] DSL_WORD_ONES = 14'h3fff;
  // path states
  typedef enum logic [1:0] {
    DSL_ST_DOWN = 2'b00,
    DSL_ST_FILL = 2'b01,
    DSL_ST_RUN = 2'b10
  } dsl_state_e;
endpackage : dsl_pkg

// >>> dsl_sample_latch.sv
// module: differential sample input latch and fixed-latency word path
// What this block does
// - bit is one at +threshold, zero at -threshold differential
// - polarity holds for swings up to the maximum across common mode
// - with loop bypass high, word reaches core three clocks after capture
// - bit 13 is msb, bit 0 lsb on true and complement sets
// - all ones steers full current to the primary output
// - all zeros steers full current to the complement output
// - power-down is asynchronous, active high, pulled low when undriven; here the pin goes through a two-flop synchronizer and acts on clock edges
// - word is unsigned straight binary, primary current linear in code
module dsl_sample_latch
  import dsl_pkg::*;
#(
  parameter int WORD_W = DSL_WORD_W,
  parameter int LAT = DSL_LAT_CLK,
  parameter int DEPTH = DSL_FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // differential sample lines, each line in signed mV
  input wire logic signed [DSL_DIFF_W-1:0] data_true_mv [WORD_W],
  input wire logic signed [DSL_DIFF_W-1:0] data_comp_mv [WORD_W],
  // control pins
  input wire logic delay_loop_bypass,
  input wire logic power_down,
  // core side: steering word for the current switches
  output logic [WORD_W-1:0] core_word,
  output logic core_valid,
  output logic primary_full_scale,
  output logic complement_full_scale,
  output logic powered_down
);
  // ==========================================
  // resolver
  // decision per differential pair
  function automatic logic resolve_bit(
    input logic signed [DSL_DIFF_W-1:0] p,
    input logic signed [DSL_DIFF_W-1:0] n,
    input logic prev
  );
    logic signed [DSL_DIFF_W:0] d;
    d = {p[DSL_DIFF_W-1], p} - {n[DSL_DIFF_W-1], n};
    if (d >= (DSL_DIFF_W+1)'(DSL_TH_MV)) begin
      resolve_bit = 1'b1;
    end else if (d <= -(DSL_DIFF_W+1)'(DSL_TH_MV)) begin
      resolve_bit = 1'b0;
    end else begin
      resolve_bit = prev; // inside dead band: receiver keeps last level
    end
  endfunction : resolve_bit

  logic [WORD_W-1:0] rx_word;
  logic [WORD_W-1:0] cap_r;
  logic [WORD_W-1:0] cap_nxt;
  logic pd_m_r;
  logic pd_r;
  logic byp_m_r;
  logic byp_r;
  logic cap_vld_r;
  logic [WORD_W-1:0] pipe_r [LAT];
  logic [LAT-1:0] pv_r;
  logic [WORD_W-1:0] fifo_data;
  logic fifo_valid;
  logic [$clog2(DEPTH):0] fifo_level;
  dsl_state_e state_r;
  dsl_fifo_if #(.W(WORD_W)) cap_if ();

  // full swing keeps polarity since difference is wide enough
  // index i maps pair i, bit 13 msb
  always_comb begin
    for (int i = 0; i < WORD_W; i++) begin
      rx_word[i] = resolve_bit(data_true_mv[i], data_comp_mv[i], cap_r[i]);
    end
  end
  assign cap_nxt = rx_word;

  // ==========================================
  // pin synchronisers
  // power-down pin, two flops; the pin pull-down lives in the pad
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pd_m_r <= 1'b0;
      pd_r <= 1'b0;
      byp_m_r <= 1'b0;
      byp_r <= 1'b0;
    end else begin
      pd_m_r <= power_down;
      pd_r <= pd_m_r;
      byp_m_r <= delay_loop_bypass;
      byp_r <= byp_m_r;
    end
  end

  // ==========================================
  // capture
  // one word taken each rising edge, valid while power-down is low
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cap_r <= DSL_WORD_RST;
      cap_vld_r <= 1'b0;
    end else begin
      cap_r <= cap_nxt;
      cap_vld_r <= !pd_r;
    end
  end
  assign cap_if.data = cap_r;
  assign cap_if.valid = cap_vld_r;

  // ==========================================
  // latency pipeline
  // fixed delay stages; stage 0 is loaded from the capture register
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pv_r <= '0;
      for (int i = 0; i < LAT; i++) begin
        pipe_r[i] <= DSL_WORD_RST;
      end
    end else begin
      pipe_r[0] <= cap_r;
      pv_r[0] <= cap_vld_r && byp_r;
      for (int i = 1; i < LAT; i++) begin
        pipe_r[i] <= pipe_r[i-1];
        pv_r[i] <= pv_r[i-1];
      end
    end
  end

  // fifo carries words when the loop is not bypassed; depth soaks jitter
  dsl_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .in_s(cap_if.snk),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(state_r == DSL_ST_RUN),
    .level(fifo_level)
  );

  // ==========================================
  // path state
  // power-down overrides everything; fill waits half depth unless bypass is high
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_r <= DSL_ST_DOWN;
    end else begin
      case (state_r)
        DSL_ST_DOWN: begin
          if (!pd_r) begin
            state_r <= DSL_ST_FILL;
          end
        end
        DSL_ST_FILL: begin
          if (pd_r) begin
            state_r <= DSL_ST_DOWN;
          end else if (byp_r || fifo_level >= ($clog2(DEPTH)+1)'(DEPTH/2)) begin
            state_r <= DSL_ST_RUN;
          end
        end
        DSL_ST_RUN: begin
          if (pd_r) begin
            state_r <= DSL_ST_DOWN;
          end
        end
        default: begin
          state_r <= DSL_ST_DOWN;
        end
      endcase
    end
  end

  // ==========================================
  // core outputs
  // word passed unchanged as straight binary code
  // all ones flags primary full scale
  // all zeros flags complement full scale
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      core_word <= DSL_WORD_RST;
      core_valid <= 1'b0;
      primary_full_scale <= 1'b0;
      complement_full_scale <= 1'b0;
      powered_down <= 1'b1;
    end else begin
      powered_down <= pd_r;
      if (pd_r) begin
        core_valid <= 1'b0;
      end else if (byp_r) begin
        core_word <= pipe_r[LAT-2];
        core_valid <= pv_r[LAT-2];
        primary_full_scale <= pipe_r[LAT-2] == DSL_WORD_ONES;
        complement_full_scale <= pipe_r[LAT-2] == DSL_WORD_RST;
      end else begin
        core_word <= fifo_data;
        core_valid <= fifo_valid && state_r == DSL_ST_RUN;
        primary_full_scale <= fifo_data == DSL_WORD_ONES;
        complement_full_scale <= fifo_data == DSL_WORD_RST;
      end
    end
  end

  // ==========================================
  // assertions
  a_bypass_latency: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (byp_r && !pd_r && cap_vld_r) ##1 (byp_r && !pd_r)[*3]
      |-> core_word == $past(cap_r, 3) && core_valid)
    else $error("bypass latency not three clocks");
  a_prim_full: assert property (@(posedge ref_clk) disable iff (!rst_b)
    core_word == DSL_WORD_ONES && core_valid |-> primary_full_scale)
    else $error("all ones not primary full scale");
  a_comp_full: assert property (@(posedge ref_clk) disable iff (!rst_b)
    core_word == DSL_WORD_RST && core_valid |-> complement_full_scale)
    else $error("all zeros not complement full scale");
  a_pd_stops: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pd_r |=> !core_valid && powered_down)
    else $error("power-down did not stop output");
  a_bit_high: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (data_true_mv[DSL_MSB] - data_comp_mv[DSL_MSB] >= DSL_TH_MV)
      |=> cap_r[DSL_MSB])
    else $error("msb above threshold not one");
  a_bit_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (data_comp_mv[DSL_LSB] - data_true_mv[DSL_LSB] >= DSL_TH_MV)
      |=> !cap_r[DSL_LSB])
    else $error("lsb below threshold not zero");
  a_swing_high: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (data_true_mv[DSL_LSB] - data_comp_mv[DSL_LSB] >= DSL_SWING_MV)
      |=> cap_r[DSL_LSB])
    else $error("lsb at full swing not one");
  a_word_kept: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (byp_r && !pd_r)[*3] |=> core_word == $past(pipe_r[LAT-2], 1))
    else $error("word changed on the way to core");
  a_one_per_clk: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !pd_r |=> cap_vld_r)
    else $error("capture skipped a clock");
  c_bypass_run: cover property (@(posedge ref_clk) byp_r && core_valid);
  c_fifo_run: cover property (@(posedge ref_clk) !byp_r && core_valid);
  c_power_cycle: cover property (@(posedge ref_clk) pd_r ##[1:20] !pd_r);
endmodule : dsl_sample_latch

// >>> tb_dac_sample_input_latch.sv
// testbench: latency, coding, thresholds and power-down of the latch
module tb_dac_sample_input_latch;
  import dsl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic delay_loop_bypass = 1'b1;
  logic power_down = 1'b0;
  logic [13:0] word = 14'h0000;
  logic signed [11:0] half_mv = 12'sd50;
  logic signed [11:0] cm_mv = 12'sd1200;
  logic signed [11:0] true_mv [14];
  logic signed [11:0] comp_mv [14];
  logic [13:0] core_word;
  logic core_valid, primary_full_scale, complement_full_scale;
  logic powered_down;
  int err_total = 0;
  int compares = 0;
  logic [13:0] wq [$];
  // 200 MHz converter clock
  always #2.5 ref_clk = ~ref_clk;
  // ==========================================================
  // instances
  dsl_host_model dsl_host_model_i (.word(word), .half_mv(half_mv),
    .cm_mv(cm_mv), .true_mv(true_mv), .comp_mv(comp_mv));
  dsl_sample_latch dsl_sample_latch_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .data_true_mv(true_mv), .data_comp_mv(comp_mv),
    .delay_loop_bypass(delay_loop_bypass), .power_down(power_down),
    .core_word(core_word), .core_valid(core_valid),
    .primary_full_scale(primary_full_scale),
    .complement_full_scale(complement_full_scale),
    .powered_down(powered_down));
  // ==========================================================
  // shared tasks
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  // back to back words; each expected four edges after its drive edge
  task automatic push_check(input logic signed [11:0] h,
                            input logic signed [11:0] c);
    logic [13:0] e;
    for (int i = 0; i < wq.size() + 4; i++) begin
      @(posedge ref_clk);
      // new line levels go out with the first word of the run
      if (i == 0) begin
        half_mv <= h;
        cm_mv <= c;
      end
      if (i < wq.size()) word <= wq[i];
      #1;
      if (i >= 4) begin
        e = wq[i-4];
        check(core_word, e);
        check({13'h0, core_valid}, 14'h0001);
        check({13'h0, primary_full_scale}, {13'h0, e == 14'h3fff});
        check({13'h0, complement_full_scale}, {13'h0, e == 14'h0});
      end
    end
  endtask : push_check
  // bounded wait for powered_down to reach a level
  task automatic wait_pd(input logic lvl);
    int n;
    n = 0;
    while (powered_down !== lvl && n < 12) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check({13'h0, powered_down}, {13'h0, lvl});
    if (powered_down !== lvl) report_and_stop();
  endtask : wait_pd
  // ==========================================================
  // scenarios
  task automatic sc_latency();
    wq = '{14'h0001, 14'h2abc, 14'h1543, 14'h3fff, 14'h0000, 14'h3fff,
           14'h3ffe, 14'h0000};
    push_check(12'sd50, 12'sd1200);
  endtask : sc_latency
  // walking one at maximum swing, low common mode
  task automatic sc_bit_order();
    wq.delete();
    for (int i = 0; i < 14; i++) wq.push_back(14'h0001 << i);
    push_check(12'sd300, 12'sd300);
  endtask : sc_bit_order
  task automatic sc_threshold();
    wq = '{14'h3fff, 14'h0000, 14'h2aaa, 14'h1555, 14'h0000};
    push_check(12'sd50, 12'sd50);
  endtask : sc_threshold
  task automatic sc_power_down();
    @(posedge ref_clk);
    power_down <= 1'b1;
    wait_pd(1'b1);
    @(posedge ref_clk);
    #1;
    check({13'h0, core_valid}, 14'h0000);
    @(posedge ref_clk);
    power_down <= 1'b0;
    wait_pd(1'b0);
    wq = '{14'h0f0f, 14'h30c3};
    push_check(12'sd50, 12'sd1200);
  endtask : sc_power_down
  // fifo path with bypass low: words leave in order, one per clock
  task automatic sc_fifo_path();
    int k;
    k = 0;
    wq = '{14'h1234, 14'h0abc, 14'h3fff, 14'h0000, 14'h2468};
    @(posedge ref_clk);
    delay_loop_bypass <= 1'b0;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 40 && k < 5; i++) begin
      @(posedge ref_clk);
      if (i < 5) word <= wq[i];
      #1;
      if (k > 0 || (core_valid === 1'b1 && core_word === wq[0])) begin
        check(core_word, wq[k]);
        check({13'h0, core_valid}, 14'h0001);
        check({13'h0, primary_full_scale}, {13'h0, wq[k] == 14'h3fff});
        check({13'h0, complement_full_scale}, {13'h0, wq[k] == 14'h0});
        k++;
      end
    end
    // a short count means the bound ran out before all words came
    check(14'(k), 14'h0005);
  endtask : sc_fifo_path
  // ==========================================================
  // main sequence; reset held five cycles, then sync flops settle
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    sc_latency();
    sc_bit_order();
    sc_threshold();
    sc_power_down();
    sc_fifo_path();
    report_and_stop();
  end
endmodule : tb_dac_sample_input_latch
